// *** cp_pkg.sv ***
/*
  Shared constants and types for the cipher processor host control.
  Assumes a single clock domain; included by package name only.
*/
package cp_pkg;
  // Master port addresses
  localparam logic [2:0] ADDR_SHIFT = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_PORT_CFG = 3'h2;
  localparam logic [2:0] ADDR_PROG_ADDR = 3'h3;
  localparam logic [2:0] ADDR_INSTR1 = 3'h4;
  localparam logic [2:0] ADDR_INSTR2 = 3'h5;
  localparam logic [2:0] ADDR_INSTR3 = 3'h6;
  // Status bit positions, and the input flag bit of the port configuration
  localparam int ST_KEY_REQ = 3;
  localparam int ST_IN_FULL = 4;
  localparam int ST_OUT_EMPTY = 5;
  localparam int ST_ACTIVITY = 6;
  localparam int ST_PARITY = 7;
  localparam int CFG_INPUT_FLAG = 7;
  // Port configuration codes, bit 7 excluded
  localparam logic [6:0] CFG_PAR_M_IN_S_OUT = 7'h04;
  localparam logic [6:0] CFG_PAR_S_IN_M_OUT = 7'h11;
  localparam logic [6:0] CFG_PAR_M_ONLY = 7'h01;
  localparam logic [6:0] CFG_SER_M_IN_S_OUT = 7'h28;
  localparam logic [6:0] CFG_SER_S_IN_M_OUT = 7'h62;
  localparam logic [6:0] CFG_MIX_M_IN_S_OUT = 7'h08;
  localparam logic [6:0] CFG_MIX_S_IN_M_OUT = 7'h61;
  // Program memory
  localparam int PC_W = 6;
  localparam int INSTR_W = 22;
  localparam int RAM_DEPTH = 32;
  localparam logic [5:0] START_IV_LOAD = 6'h06;
  localparam logic [5:0] START_KEY_LOAD = 6'h0b;
  localparam logic [5:0] START_SERIAL_KEY = 6'h10;
  localparam logic [5:0] RAM_BASE = 6'h20;
  // Transfer sizes and timing
  localparam int BLOCK_BYTES = 8;
  localparam int KEY_BITS = 64;
  localparam int CLKS_PER_INSTR = 2;
  // Reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h00;
  localparam logic [5:0] RST_PROG_ADDR = 6'h00;
  localparam logic RST_BUF_FLAG = 1'b1;
  typedef enum logic [2:0] {
    CP_ROUTE_M_TO_S = 3'b001,
    CP_ROUTE_S_TO_M = 3'b010,
    CP_ROUTE_M_ONLY = 3'b100
  } cp_route_t;
endpackage

// *** cp_div.sv ***
/*
  Instruction cycle divider: one-cycle tick every DIV clocks.
  Assumes DIV of at least 2.
*/
`timescale 1ns/1ps
module cp_div #(
  parameter int DIV = cp_pkg::CLKS_PER_INSTR
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [$clog2(DIV)-1:0] count;

  // Free running count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (count == $clog2(DIV)'(DIV - 1));
      if (count == $clog2(DIV)'(DIV - 1))
        count <= '0;
      else
        count <= count + 1'b1;
    end
  end
endmodule

// *** cp_serial_key.sv ***
/*
  Serial key receiver: shifts key bits on falling key clock edges.
  Assumes key clock and data are synchronous to clk and slower than it.
*/
`timescale 1ns/1ps
module cp_serial_key #(
  parameter int BITS = cp_pkg::KEY_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic key_serial_clock,
  input wire logic key_serial_data,
  output logic [BITS-1:0] key_word,
  output logic done
);
  logic sclk_prev;
  logic [$clog2(BITS):0] count;
  logic fall;

  assign fall = sclk_prev && !key_serial_clock;

  // Bits latched on falling edge, ignored after the last
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev <= 1'b0;
      count <= '0;
      key_word <= '0;
      done <= 1'b0;
    end
    else
    begin
      sclk_prev <= key_serial_clock;
      done <= 1'b0;
      if (!enable)
        count <= '0;
      else if (fall && count != ($clog2(BITS)+1)'(BITS))
      begin
        key_word <= {key_word[BITS-2:0], key_serial_data};
        count <= count + 1'b1;
        done <= (count == ($clog2(BITS)+1)'(BITS - 1));
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_serial_stop;
    enable && count == ($clog2(BITS)+1)'(BITS) |=> $stable(key_word);
  endproperty
  a_serial_stop: assert property (p_serial_stop) else $error("Key bit taken after last");
endmodule

// *** cp_host_ctrl.sv ***
/*
  Host control of a microcoded cipher processor: status flags and pins,
  port routing, program address control, program RAM, shift registers.
  Assumes host strobes are one-cycle pulses synchronous to clk and that
  microcode op inputs come from the instruction decoder, valid on instr_en.
*/
`timescale 1ns/1ps
module cp_host_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] master_addr,
  input wire logic master_read_strobe,
  input wire logic master_write_strobe,
  input wire logic [7:0] master_data_in,
  output logic [7:0] master_data_out,
  output logic master_data_oe,
  input wire logic [2:0] slave_addr,
  input wire logic slave_read_strobe,
  input wire logic slave_write_strobe,
  input wire logic [7:0] slave_data_in,
  output logic [7:0] slave_data_out,
  output logic slave_data_oe,
  input wire logic key_serial_clock,
  input wire logic key_serial_data,
  input wire logic op_set_buffer_flags,
  input wire logic op_clear_output_empty,
  input wire logic op_clear_input_full,
  input wire logic op_activity_set,
  input wire logic op_activity_clear,
  input wire logic op_serial,
  input wire logic op_key_write,
  input wire logic jump_valid,
  input wire logic [5:0] jump_addr,
  input wire logic [21:0] rom_word,
  input wire logic osr_load,
  input wire logic [63:0] osr_data,
  output logic instr_en,
  output logic [5:0] program_counter,
  output logic [21:0] instr_word,
  output logic input_flag,
  output logic [1:0] key_select,
  output logic [63:0] isr_data,
  output logic key_load_strobe,
  output logic [63:0] key_load_data,
  output logic master_flag_a,
  output logic master_flag_b,
  output logic slave_flag,
  output logic activity_pin,
  output logic key_request_n,
  output logic parity_fail_n
);
  logic [7:0] port_cfg;
  logic [5:0] prog_addr;
  logic load_pending;
  logic input_full;
  logic output_empty;
  logic activity;
  logic key_request;
  logic parity_fail;
  logic [63:0] output_shift_reg;
  logic [2:0] isr_count;
  logic [2:0] osr_count;
  logic [21:0] ram [cp_pkg::RAM_DEPTH];
  logic [63:0] serial_word;
  logic serial_done;
  cp_pkg::cp_route_t route;
  logic mode_wr;
  logic in_wr;
  logic [7:0] in_byte;
  logic out_rd;
  logic isr_take;
  logic isr_last;
  logic osr_take;
  logic osr_last;
  logic ram_sel;
  logic [21:0] ram_word;
  logic [5:0] next_pc;
  logic [7:0] status;

  function automatic cp_pkg::cp_route_t route_of(input logic [6:0] code);
    case (code)
      cp_pkg::CFG_PAR_M_IN_S_OUT, cp_pkg::CFG_SER_M_IN_S_OUT, cp_pkg::CFG_MIX_M_IN_S_OUT:
        route_of = cp_pkg::CP_ROUTE_M_TO_S;
      cp_pkg::CFG_PAR_S_IN_M_OUT, cp_pkg::CFG_SER_S_IN_M_OUT, cp_pkg::CFG_MIX_S_IN_M_OUT:
        route_of = cp_pkg::CP_ROUTE_S_TO_M;
      default:
        route_of = cp_pkg::CP_ROUTE_M_ONLY;
    endcase
  endfunction

  function automatic logic even_byte_parity(input logic [63:0] w);
    even_byte_parity = 1'b0;
    for (int i = 0; i < cp_pkg::BLOCK_BYTES; i++)
      if (!(^w[8*i +: 8]))
        even_byte_parity = 1'b1;
  endfunction

  cp_div #(.DIV(cp_pkg::CLKS_PER_INSTR)) u_div (
    .clk(clk),
    .rst(rst),
    .tick(instr_en)
  );

  cp_serial_key #(.BITS(cp_pkg::KEY_BITS)) u_serial (
    .clk(clk),
    .rst(rst),
    .enable(key_request),
    .key_serial_clock(key_serial_clock),
    .key_serial_data(key_serial_data),
    .key_word(serial_word),
    .done(serial_done)
  );

  // Port routing and access decode
  assign route = route_of(port_cfg[6:0]);
  assign mode_wr = master_write_strobe && master_addr == cp_pkg::ADDR_PROG_ADDR;
  assign ram_sel = prog_addr[5];
  assign ram_word = ram[prog_addr[4:0]];
  assign input_flag = port_cfg[cp_pkg::CFG_INPUT_FLAG];

  always_comb
  begin
    in_wr = 1'b0;
    in_byte = master_data_in;
    out_rd = 1'b0;
    if (route == cp_pkg::CP_ROUTE_S_TO_M)
    begin
      in_wr = slave_write_strobe && slave_addr == cp_pkg::ADDR_SHIFT;
      in_byte = slave_data_in;
      out_rd = master_read_strobe && master_addr == cp_pkg::ADDR_SHIFT;
    end
    else
    begin
      in_wr = master_write_strobe && master_addr == cp_pkg::ADDR_SHIFT;
      if (route == cp_pkg::CP_ROUTE_M_TO_S)
        out_rd = slave_read_strobe && slave_addr == cp_pkg::ADDR_SHIFT;
      else
        out_rd = master_read_strobe && master_addr == cp_pkg::ADDR_SHIFT;
    end
  end

  assign isr_take = in_wr && !input_full;
  assign isr_last = isr_take && isr_count == 3'(cp_pkg::BLOCK_BYTES - 1);
  assign osr_take = out_rd && !output_empty;
  assign osr_last = osr_take && osr_count == 3'(cp_pkg::BLOCK_BYTES - 1);

  assign status = {parity_fail, activity, output_empty, input_full, key_request, 1'b0,
    key_select};

  // Flag pins follow routing
  always_comb
  begin
    master_flag_a = output_empty;
    master_flag_b = input_full;
    slave_flag = 1'b0;
    case (route)
      cp_pkg::CP_ROUTE_M_TO_S:
      begin
        master_flag_a = input_full;
        master_flag_b = 1'b0;
        slave_flag = output_empty;
      end
      cp_pkg::CP_ROUTE_S_TO_M:
      begin
        master_flag_a = output_empty;
        master_flag_b = 1'b0;
        slave_flag = input_full;
      end
      default:
      begin
        master_flag_a = output_empty;
        master_flag_b = input_full;
      end
    endcase
  end

  assign activity_pin = activity;
  assign key_request_n = !key_request;
  assign parity_fail_n = !parity_fail;

  // Master-only configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      port_cfg <= cp_pkg::RST_PORT_CFG;
      prog_addr <= cp_pkg::RST_PROG_ADDR;
      key_select <= 2'h0;
    end
    else if (master_write_strobe)
    begin
      if (master_addr == cp_pkg::ADDR_PORT_CFG)
        port_cfg <= master_data_in;
      if (master_addr == cp_pkg::ADDR_PROG_ADDR)
        prog_addr <= master_data_in[5:0];
      if (master_addr == cp_pkg::ADDR_STATUS)
        key_select <= master_data_in[1:0];
    end
  end

  // Program RAM byte writes
  always_ff @(posedge clk)
  begin
    if (master_write_strobe && ram_sel)
    begin
      if (master_addr == cp_pkg::ADDR_INSTR1)
        ram[prog_addr[4:0]][7:0] <= master_data_in;
      if (master_addr == cp_pkg::ADDR_INSTR2)
        ram[prog_addr[4:0]][15:8] <= master_data_in;
      if (master_addr == cp_pkg::ADDR_INSTR3)
        ram[prog_addr[4:0]][21:16] <= master_data_in[5:0];
    end
  end

  // Program counter
  always_comb
  begin
    if (load_pending)
      next_pc = prog_addr;
    else if (jump_valid)
      next_pc = jump_addr;
    else
      next_pc = program_counter + 6'h01;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      load_pending <= 1'b0;
      program_counter <= cp_pkg::RST_PROG_ADDR;
      instr_word <= '0;
    end
    else
    begin
      if (mode_wr)
        load_pending <= 1'b1;
      else if (instr_en)
        load_pending <= 1'b0;
      if (instr_en)
        program_counter <= next_pc;
      instr_word <= program_counter[5] ? ram[program_counter[4:0]] : rom_word;
    end
  end

  // Buffer flags: set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      input_full <= cp_pkg::RST_BUF_FLAG;
      output_empty <= cp_pkg::RST_BUF_FLAG;
    end
    else
    begin
      if (mode_wr || (instr_en && op_set_buffer_flags) || isr_last || serial_done)
        input_full <= 1'b1;
      else if (instr_en && op_clear_input_full)
        input_full <= 1'b0;
      if (mode_wr || (instr_en && op_set_buffer_flags) || osr_last)
        output_empty <= 1'b1;
      else if (instr_en && op_clear_output_empty)
        output_empty <= 1'b0;
    end
  end

  // Input shift register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      isr_data <= '0;
      isr_count <= 3'h0;
    end
    else if (serial_done)
      isr_data <= serial_word;
    else if (mode_wr || (instr_en && op_clear_input_full))
      isr_count <= 3'h0;
    else if (isr_take)
    begin
      isr_data <= {isr_data[55:0], in_byte};
      isr_count <= isr_count + 3'h1;
    end
  end

  // Output shift register, most significant byte first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      output_shift_reg <= '0;
      osr_count <= 3'h0;
    end
    else if (osr_load)
    begin
      output_shift_reg <= osr_data;
      osr_count <= 3'h0;
    end
    else if (osr_take)
    begin
      output_shift_reg <= {output_shift_reg[55:0], 8'h00};
      osr_count <= osr_count + 3'h1;
    end
  end

  // Activity, key request, parity
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      activity <= 1'b0;
      key_request <= 1'b0;
      parity_fail <= 1'b0;
      key_load_strobe <= 1'b0;
      key_load_data <= '0;
    end
    else
    begin
      key_load_strobe <= instr_en && op_key_write;
      if (instr_en && op_activity_set)
        activity <= 1'b1;
      else if (instr_en && op_activity_clear)
        activity <= 1'b0;
      if (instr_en && op_activity_set && op_serial)
        key_request <= 1'b1;
      else if (instr_en && op_activity_clear)
        key_request <= 1'b0;
      if (instr_en && op_key_write)
      begin
        parity_fail <= even_byte_parity(isr_data);
        key_load_data <= isr_data;
      end
    end
  end

  // Read data, registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      master_data_out <= 8'h00;
      master_data_oe <= 1'b0;
      slave_data_out <= 8'h00;
      slave_data_oe <= 1'b0;
    end
    else
    begin
      master_data_oe <= master_read_strobe;
      slave_data_oe <= slave_read_strobe;
      if (master_read_strobe)
        case (master_addr)
          cp_pkg::ADDR_SHIFT: master_data_out <= osr_take ? output_shift_reg[63:56] : 8'h00;
          cp_pkg::ADDR_STATUS: master_data_out <= status;
          cp_pkg::ADDR_PORT_CFG: master_data_out <= port_cfg;
          cp_pkg::ADDR_PROG_ADDR: master_data_out <= {2'h0, prog_addr};
          cp_pkg::ADDR_INSTR1: master_data_out <= ram_sel ? ram_word[7:0] : 8'h00;
          cp_pkg::ADDR_INSTR2: master_data_out <= ram_sel ? ram_word[15:8] : 8'h00;
          cp_pkg::ADDR_INSTR3: master_data_out <= ram_sel ? {2'h0, ram_word[21:16]} : 8'h00;
          default: master_data_out <= 8'h00;
        endcase
      if (slave_read_strobe)
        case (slave_addr)
          cp_pkg::ADDR_SHIFT: slave_data_out <= osr_take ? output_shift_reg[63:56] : 8'h00;
          cp_pkg::ADDR_STATUS: slave_data_out <= status;
          default: slave_data_out <= 8'h00;
        endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_mode_sets_flags;
    mode_wr |=> output_empty && input_full;
  endproperty
  a_mode_sets_flags: assert property (p_mode_sets_flags) else $error("Flags not set");

  property p_empty_blocks_read;
    output_empty && out_rd && !osr_load |=> $stable(output_shift_reg) && $stable(osr_count);
  endproperty
  a_empty_blocks_read: assert property (p_empty_blocks_read) else $error("Read not ignored");

  property p_activity_set;
    instr_en && op_activity_set |=> activity_pin ##1 activity_pin;
  endproperty
  a_activity_set: assert property (p_activity_set) else $error("Activity not set");

  property p_parity;
    instr_en && op_key_write && even_byte_parity(isr_data) |=> !parity_fail_n;
  endproperty
  a_parity: assert property (p_parity) else $error("Parity fail missed");

  property p_slave_no_cfg;
    slave_write_strobe && !master_write_strobe |=> $stable(port_cfg);
  endproperty
  a_slave_no_cfg: assert property (p_slave_no_cfg) else $error("Slave changed config");

  property p_flag_route;
    route == cp_pkg::CP_ROUTE_M_TO_S |-> master_flag_a == input_full && slave_flag == output_empty;
  endproperty
  a_flag_route: assert property (p_flag_route) else $error("Flag routing wrong");

  property p_pc_load;
    mode_wr ##[1:2] (instr_en && !mode_wr) |=> program_counter == prog_addr;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("Start address not loaded");

  property p_eighth_byte;
    isr_last |=> input_full && isr_count == 3'h0;
  endproperty
  a_eighth_byte: assert property (p_eighth_byte) else $error("Input full not set");

  property p_status_write;
    master_write_strobe && master_addr == cp_pkg::ADDR_STATUS && !instr_en && !mode_wr
      |=> key_select == $past(master_data_in[1:0]) && $stable(activity);
  endproperty
  a_status_write: assert property (p_status_write) else $error("Status write wrong");

  c_block_in: cover property (isr_last);
  c_block_out: cover property (osr_last);
  c_serial_key: cover property (serial_done);
endmodule

// *** cp_host_model.sv ***
/*
  Far-side model: microcode decoder and serial key source.
  Assumes master-only routing, so master_flag_b is the input full flag.
*/
`timescale 1ns/1ps
module cp_host_model #(
  parameter logic [63:0] KEY = 64'h0123456789abcdef
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_en,
  input wire logic [5:0] program_counter,
  input wire logic input_full,
  input wire logic key_request_n,
  output logic op_set_buffer_flags,
  output logic op_clear_output_empty,
  output logic op_clear_input_full,
  output logic op_activity_set,
  output logic op_activity_clear,
  output logic op_serial,
  output logic op_key_write,
  output logic jump_valid,
  output logic [5:0] jump_addr,
  output logic key_serial_clock,
  output logic key_serial_data
);
  logic [1:0] st;
  logic [5:0] last_pc;
  logic [8:0] cnt;
  logic is_load;
  assign is_load = program_counter inside {cp_pkg::START_IV_LOAD, cp_pkg::START_KEY_LOAD,
    cp_pkg::START_SERIAL_KEY};
  // Hold the program counter where the host put it
  assign jump_valid = 1'b1;
  assign jump_addr = program_counter;
  assign op_set_buffer_flags = 1'b0;
  // Load programs: activity on, input full cleared
  assign op_activity_set = st == 2'h0 && is_load;
  assign op_clear_input_full = op_activity_set;
  assign op_serial = op_activity_set && program_counter == cp_pkg::START_SERIAL_KEY;
  assign op_clear_output_empty = st == 2'h0 && program_counter == cp_pkg::RAM_BASE;
  // Block in: activity off one instruction later, with a key write except in the IV load
  assign op_activity_clear = st == 2'h1 && input_full;
  assign op_key_write = op_activity_clear && program_counter != cp_pkg::START_IV_LOAD;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st <= 2'h0;
      last_pc <= 6'h00;
    end
    else
    begin
      last_pc <= program_counter;
      if (program_counter != last_pc)
        st <= 2'h0;
      else if (instr_en && (op_activity_set || op_clear_output_empty))
        st <= op_activity_set ? 2'h1 : 2'h2;
      else if (instr_en && op_activity_clear)
        st <= 2'h2;
    end
  // Serial key: 66 falling edges, two beyond the key, clock still when idle
  always_ff @(posedge clk or posedge rst)
    if (rst || key_request_n)
      cnt <= 9'h000;
    else if (cnt != 9'h108)
      cnt <= cnt + 9'h001;
  // Idle high, so the first fall carries the top key bit
  assign key_serial_clock = !cnt[1];
  assign key_serial_data = cnt[8] ? cnt[2] : KEY[6'h3f - cnt[7:2]];
endmodule

// *** test_cipher_processor_host_control.sv ***
/*
  Testbench for the host control: register reads and writes, load programs,
  routing flags and output reads. Assumes cp_host_model as the decoder side.
*/
`timescale 1ns/1ps
module test_cipher_processor_host_control;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;
  logic clk = 0, rst = 1;
  logic [2:0] master_addr = 0, slave_addr = 0;
  logic master_read_strobe = 0, master_write_strobe = 0, master_data_oe, slave_data_oe;
  logic slave_read_strobe = 0, slave_write_strobe = 0;
  logic [7:0] master_data_in = 0, slave_data_in = 0, master_data_out, slave_data_out, q;
  logic key_serial_clock, key_serial_data, op_set_buffer_flags, op_clear_output_empty;
  logic op_clear_input_full, op_activity_set, op_activity_clear, op_serial, op_key_write;
  logic jump_valid, instr_en, input_flag, key_load_strobe, osr_load = 0;
  logic [5:0] jump_addr, program_counter;
  logic [21:0] rom_word = 22'h000000, instr_word;
  logic [63:0] osr_data = 0, isr_data, key_load_data;
  logic [1:0] key_select;
  logic master_flag_a, master_flag_b, slave_flag, activity_pin, key_request_n, parity_fail_n;
  logic [7:0] cd [7] = '{8'h04, 8'h11, 8'h01, 8'h28, 8'h62, 8'h08, 8'h61};
  int rt [7] = '{0, 1, 2, 0, 1, 0, 1};
  int bad_count = 0, checks_done = 0, cycles = 0;
  cp_host_ctrl DUT (.clk, .rst, .master_addr, .master_read_strobe, .master_write_strobe,
    .master_data_in, .master_data_out, .master_data_oe, .slave_addr, .slave_read_strobe,
    .slave_write_strobe, .slave_data_in, .slave_data_out, .slave_data_oe, .key_serial_clock,
    .key_serial_data, .op_set_buffer_flags, .op_clear_output_empty, .op_clear_input_full,
    .op_activity_set, .op_activity_clear, .op_serial, .op_key_write, .jump_valid, .jump_addr,
    .rom_word, .osr_load, .osr_data, .instr_en, .program_counter, .instr_word, .input_flag,
    .key_select, .isr_data, .key_load_strobe, .key_load_data, .master_flag_a, .master_flag_b,
    .slave_flag, .activity_pin, .key_request_n, .parity_fail_n);
  cp_host_model #(.KEY(KEY)) partner (.clk, .rst, .instr_en, .program_counter,
    .input_full(master_flag_b), .key_request_n, .op_set_buffer_flags, .op_clear_output_empty,
    .op_clear_input_full, .op_activity_set, .op_activity_clear, .op_serial, .op_key_write,
    .jump_valid, .jump_addr, .key_serial_clock, .key_serial_data);
  always #10 clk = ~clk;
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One strobe cycle; read data sampled in the cycle after it
  task automatic acc(input logic s, input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    master_addr = a;
    slave_addr = a;
    master_data_in = d;
    slave_data_in = d;
    master_write_strobe = !s && w;
    master_read_strobe = !s && !w;
    slave_write_strobe = s && w;
    slave_read_strobe = s && !w;
    @(posedge clk) #1;
    {master_read_strobe, master_write_strobe, slave_read_strobe, slave_write_strobe} = 4'h0;
    q = s ? slave_data_out : master_data_out;
    chk(s ? slave_data_oe : master_data_oe, !w);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic run_block(input logic [5:0] start, input logic [63:0] blk);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, {2'h0, start});
    settle();
    chk(activity_pin, 1);
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q[4], 0);
    for (int i = 7; i >= 0; i--)
      acc(0, 1, cp_pkg::ADDR_SHIFT, blk[8*i+:8]);
    chk(isr_data, blk);
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q[4], 1);
    acc(0, 1, cp_pkg::ADDR_SHIFT, 8'h5a);
    chk(isr_data, blk);
    settle();
    chk(activity_pin, 0);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q, 8'h30);
    chk({master_flag_a, master_flag_b, slave_flag, parity_fail_n, key_request_n}, 5'h1b);
    acc(0, 1, cp_pkg::ADDR_STATUS, 8'hff);
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q, 8'h33);
    chk(key_select, 2'h3);
    acc(1, 1, cp_pkg::ADDR_STATUS, 8'h00);
    acc(1, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q, 8'h33);
    acc(0, 1, cp_pkg::ADDR_STATUS, 8'h01);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, 8'hff);
    acc(0, 0, cp_pkg::ADDR_PROG_ADDR, 0);
    chk(q, 8'h3f);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, 8'h25);
    acc(0, 1, cp_pkg::ADDR_INSTR1, 8'ha5);
    acc(0, 1, cp_pkg::ADDR_INSTR2, 8'h5a);
    acc(0, 1, cp_pkg::ADDR_INSTR3, 8'hff);
    acc(0, 0, cp_pkg::ADDR_INSTR3, 0);
    chk(q, 8'h3f);
    acc(0, 0, cp_pkg::ADDR_INSTR1, 0);
    chk(q, 8'ha5);
    settle();
    chk(program_counter, 6'h25);
    chk(instr_word, 22'h3f5aa5);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, 8'h05);
    acc(0, 1, cp_pkg::ADDR_INSTR1, 8'h77);
    acc(0, 0, cp_pkg::ADDR_INSTR1, 0);
    chk(q, 8'h00);
    acc(0, 1, cp_pkg::ADDR_PORT_CFG, 8'h01);
    acc(1, 0, cp_pkg::ADDR_PORT_CFG, 0);
    chk(q, 8'h00);
    acc(1, 1, cp_pkg::ADDR_PORT_CFG, 8'h04);
    acc(0, 0, cp_pkg::ADDR_PORT_CFG, 0);
    chk(q, 8'h01);
    run_block(cp_pkg::START_IV_LOAD, 64'h1122334455667788);
    run_block(cp_pkg::START_KEY_LOAD, 64'h0123456789abcd00);
    chk(parity_fail_n, 0);
    chk(key_load_data, 64'h0123456789abcd00);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, {2'h0, cp_pkg::START_SERIAL_KEY});
    settle();
    chk({activity_pin, key_request_n}, 2'h2);
    for (int i = 0; i < 400 && activity_pin !== 1'b0; i++)
      @(posedge clk) #1;
    chk(key_load_strobe, 1);
    chk(key_load_data, KEY);
    chk({parity_fail_n, key_request_n}, 2'h3);
    @(posedge clk) #1 osr_load = 1;
    osr_data = 64'hfedcba9876543210;
    @(posedge clk) #1 osr_load = 0;
    acc(0, 0, cp_pkg::ADDR_SHIFT, 0);
    chk(q, 8'h00);
    acc(0, 1, cp_pkg::ADDR_PROG_ADDR, {2'h0, cp_pkg::RAM_BASE});
    settle();
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q, 8'h11);
    for (int k = 0; k < 14; k++)
    begin
      acc(0, 1, cp_pkg::ADDR_PORT_CFG, {k[0], cd[k/2][6:0]});
      acc(0, 0, cp_pkg::ADDR_PORT_CFG, 0);
      chk(q, {k[0], cd[k/2][6:0]});
      chk(input_flag, k[0]);
      chk(master_flag_a, rt[k/2] == 0);
      chk(rt[k/2] == 2 ? master_flag_b : slave_flag, rt[k/2] != 0);
    end
    acc(0, 1, cp_pkg::ADDR_PORT_CFG, 8'h01);
    for (int i = 7; i >= 0; i--)
    begin
      acc(0, 0, cp_pkg::ADDR_SHIFT, 0);
      chk(q, osr_data[8*i+:8]);
    end
    acc(0, 0, cp_pkg::ADDR_STATUS, 0);
    chk(q[5], 1);
    acc(0, 0, cp_pkg::ADDR_SHIFT, 0);
    chk(q, 8'h00);
    finish_test();
  end
endmodule
